// [acp_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module acp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic flush_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
		$error("acp_fifo: DEPTH must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic do_wr;
	logic do_rd;
	assign wr_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign rd_valid_out = wp_q != rp_q;
	assign rd_data_out = mem_q[rp_q[AW-1:0]];
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;
	always_ff @(posedge clk_in) begin
		if (do_wr)
			mem_q[wp_q[AW-1:0]] <= wr_data_in;
	end
	always_ff @(posedge clk_in) begin
		if (srst_in || flush_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (do_wr)
				wp_q <= wp_q + 1'b1;
			if (do_rd)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule // acp_fifo
`default_nettype wire

// [acp_host_model.sv]
// Host controller model that streams ASCII characters into the parser.
`timescale 1ns/100ps
`default_nettype none
module acp_host_model (
	input wire logic clk_in,
	input wire logic rx_ready_in,
	output logic [7:0] rx_data_out,
	output logic rx_eoi_out,
	output logic rx_valid_out
);
	initial begin
		rx_data_out = 8'h00;
		rx_eoi_out = 1'b0;
		rx_valid_out = 1'b0;
	end
	// Entered just after an edge; ready is read late so it is settled.
	task automatic put(input logic [7:0] ch, input logic eoi);
		logic ok;
		rx_data_out = ch;
		rx_eoi_out = eoi;
		rx_valid_out = 1'b1;
		// A stall is bounded by the bench watchdog, which counts it as failed.
		do begin
			#3 ok = rx_ready_in;
			@(posedge clk_in);
			#1;
		end while (!ok);
	endtask
	// Valid stays up across a string; the released line shows no stale char.
	task automatic send(input string s, input logic eoi);
		for (int i = 0; i < s.len(); i++)
			put(s[i], eoi && i == s.len() - 1);
		rx_valid_out = 1'b0;
		rx_eoi_out = 1'b0;
		rx_data_out = ~rx_data_out;
	endtask
endmodule // acp_host_model
`default_nettype wire

// [acp_parser.sv]
// ASCII command parser: buffers, terminators, mnemonic decode and errors.
`timescale 1ns/100ps
`default_nettype none
module acp_parser #(
	parameter int CMD_MAX = acp_pkg::CMD_BUF_MAX,
	parameter int PAR_MAX = acp_pkg::PAR_BUF_MAX,
	parameter int NUM_KNOWN = 8,
	parameter logic [NUM_KNOWN*32-1:0] KNOWN_MNEMONICS = {
		32'h2A434C53, 32'h2A455352, 32'h2A525354, 32'h2A4F5043,
		32'h4C455252, 32'h494E5352, 32'h444C4159, 32'h54524154}
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_eoi_in,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	output logic cmd_valid_out,
	output acp_pkg::acp_cmd_t cmd_out,
	input wire logic cmd_ready_in,
	input wire logic exec_fail_in,
	input wire logic [7:0] exec_code_in,
	input wire logic inst_stat_set_in,
	input wire logic [7:0] inst_stat_bits_in,
	output logic [7:0] inst_stat_out,
	output logic [7:0] esr_out,
	output logic err_pop_in_unused_out,
	input wire logic err_pop_in,
	output logic [7:0] err_code_out,
	output logic err_empty_out,
	output logic flush_out_out
);
	// Counters are eight and five bits wide, which bounds both sizes.
	if (CMD_MAX < acp_pkg::MNEM_LEN + 1 || CMD_MAX > 255) begin : g_bad_cmd
		$error("acp_parser: command buffer size out of range");
	end
	if (PAR_MAX < 1 || PAR_MAX > 31) begin : g_bad_par
		$error("acp_parser: parameter buffer size out of range");
	end
	typedef enum {ACP_ST_IDLE, ACP_ST_RUN, ACP_ST_WAIT} acp_state_t;
	acp_state_t state_q;
	acp_pkg::acp_char_t fifo_out;
	logic fifo_valid;
	logic fifo_take;
	logic flush_q;
	logic pend_lf_q;
	logic [7:0] ch;
	logic is_term;
	logic [7:0] cnt_q;
	logic [2:0] mpos_q;
	logic [31:0] mnem_q;
	logic query_q;
	logic [1:0] pidx_q;
	logic [4:0] plen_q;
	logic [2:0] ppres_q;
	logic [2:0] pflt_q;
	logic [31:0] pint_q [acp_pkg::PAR_COUNT];
	logic pneg_q;
	logic par_ovf_q;
	logic bad_par_q;
	logic cmd_ovf;
	logic syntax_err;
	logic [7:0] syn_code;
	logic [7:0] esr_q;
	logic [7:0] inst_stat_q;
	logic [7:0] errq_q [acp_pkg::ERRQ_DEPTH];
	logic [2:0] errn_q;
	logic push_err;
	logic [7:0] push_code;
	logic do_cls;
	acp_pkg::acp_cmd_t cmd_q;

	function automatic logic [7:0] to_upper(input logic [7:0] c);
		if (c >= 8'h61 && c <= 8'h7A)
			return c & ~acp_pkg::CH_LOWER_BIT;
		return c;
	endfunction
	function automatic logic is_digit(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h39;
	endfunction
	function automatic logic known(input logic [31:0] m);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_KNOWN; i++)
			if (KNOWN_MNEMONICS[i*32 +: 32] == m)
				hit = 1'b1;
		return hit;
	endfunction

	// The FIFO lets the interface keep delivering while a command executes.
	acp_fifo #(.WIDTH(9), .DEPTH(acp_pkg::FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.flush_in(flush_q),
		.wr_data_in({rx_data_in, rx_eoi_in}),
		.wr_valid_in(rx_valid_in),
		.wr_ready_out(rx_ready_out),
		.rd_data_out(fifo_out),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(fifo_take)
	);

	// The appended line feed is injected before the next stored character.
	assign ch = pend_lf_q ? acp_pkg::CH_LF : to_upper(fifo_out.data);
	assign is_term = ch == acp_pkg::CH_SEMI || ch == acp_pkg::CH_CR ||
		ch == acp_pkg::CH_LF;
	assign fifo_take = state_q != ACP_ST_WAIT && !pend_lf_q && fifo_valid;
	wire logic step = state_q != ACP_ST_WAIT && (pend_lf_q || fifo_valid);
	assign cmd_ovf = step && !is_term && cnt_q == 8'(CMD_MAX);
	assign syn_code = par_ovf_q ? acp_pkg::ERR_PAR_OVF :
		mpos_q != 3'(acp_pkg::MNEM_LEN) ? acp_pkg::ERR_SHORT :
		bad_par_q ? acp_pkg::ERR_BAD_PAR : acp_pkg::ERR_UNKNOWN;
	assign syntax_err = step && is_term && state_q == ACP_ST_RUN &&
		(par_ovf_q || bad_par_q || mpos_q != 3'(acp_pkg::MNEM_LEN) ||
		!known(mnem_q));
	assign do_cls = cmd_valid_out && cmd_ready_in &&
		cmd_q.mnemonic == acp_pkg::MN_CLS && !cmd_q.query;
	assign push_err = syntax_err || exec_fail_in;
	assign push_code = syntax_err ? syn_code : exec_code_in;

	always_ff @(posedge clk_in) begin
		if (srst_in)
			pend_lf_q <= 1'b0;
		else if (pend_lf_q && step)
			pend_lf_q <= 1'b0;
		else if (fifo_take && fifo_out.eoi && fifo_out.data != acp_pkg::CH_LF)
			pend_lf_q <= 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in)
			flush_q <= 1'b0;
		else
			flush_q <= cmd_ovf;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || cmd_ovf) begin
			state_q <= ACP_ST_IDLE;
			cnt_q <= 8'h00;
			mpos_q <= 3'h0;
			mnem_q <= 32'h0000_0000;
			query_q <= 1'b0;
			pidx_q <= 2'h0;
			plen_q <= 5'h00;
			ppres_q <= 3'h0;
			pflt_q <= 3'h0;
			pneg_q <= 1'b0;
			par_ovf_q <= 1'b0;
			bad_par_q <= 1'b0;
			for (int i = 0; i < acp_pkg::PAR_COUNT; i++)
				pint_q[i] <= 32'h0000_0000;
		end else if (state_q == ACP_ST_WAIT) begin
			if (cmd_ready_in)
				state_q <= ACP_ST_IDLE;
		end else if (step) begin
			if (is_term) begin
				// Execution is handed on only once the terminator arrives.
				if (state_q == ACP_ST_RUN && !syntax_err)
					state_q <= ACP_ST_WAIT;
				else
					state_q <= ACP_ST_IDLE;
				cnt_q <= 8'h00;
				mpos_q <= 3'h0;
				mnem_q <= 32'h0000_0000;
				query_q <= 1'b0;
				pidx_q <= 2'h0;
				plen_q <= 5'h00;
				pneg_q <= 1'b0;
				par_ovf_q <= 1'b0;
				bad_par_q <= 1'b0;
			end else begin
				state_q <= ACP_ST_RUN;
				cnt_q <= cnt_q + 8'h01;
				if (state_q == ACP_ST_IDLE) begin
					ppres_q <= 3'h0;
					pflt_q <= 3'h0;
					for (int i = 0; i < acp_pkg::PAR_COUNT; i++)
						pint_q[i] <= 32'h0000_0000;
				end
				if (mpos_q < 3'(acp_pkg::MNEM_LEN)) begin
					mnem_q <= {mnem_q[23:0], ch};
					mpos_q <= mpos_q + 3'h1;
				end else if (ch == acp_pkg::CH_QUERY && cnt_q ==
					8'(acp_pkg::MNEM_LEN)) begin
					query_q <= 1'b1;
				end else if (ch == acp_pkg::CH_COMMA) begin
					plen_q <= 5'h00;
					pneg_q <= 1'b0;
					// Saturate so a fourth field stays inside the arrays.
					if (pidx_q == 2'(acp_pkg::PAR_COUNT - 1))
						par_ovf_q <= 1'b1;
					else
						pidx_q <= pidx_q + 2'h1;
				end else if (plen_q == 5'(PAR_MAX)) begin
					par_ovf_q <= 1'b1;
				end else begin
					// Missing parameters simply stay absent in the record.
					plen_q <= plen_q + 5'h01;
					ppres_q[pidx_q] <= 1'b1;
					if (is_digit(ch) && !pflt_q[pidx_q])
						pint_q[pidx_q] <= pint_q[pidx_q] * 32'd10 +
							{28'h0, ch[3:0]};
					else if (ch == acp_pkg::CH_DOT || ch == acp_pkg::CH_E)
						pflt_q[pidx_q] <= 1'b1;
					else if (ch == acp_pkg::CH_MINUS && plen_q == 5'h00)
						pneg_q <= 1'b1;
					else if (!(is_digit(ch) || ch == acp_pkg::CH_PLUS ||
						ch == acp_pkg::CH_MINUS))
						bad_par_q <= 1'b1;
				end
			end
		end
	end

	// Float parameters are passed as present and flagged; conversion of the
	// text to hertz, seconds or volts is left to the executing logic.
	always_ff @(posedge clk_in) begin
		if (srst_in)
			cmd_q <= '0;
		else if (step && is_term && state_q == ACP_ST_RUN && !syntax_err) begin
			cmd_q.mnemonic <= mnem_q;
			cmd_q.query <= query_q;
			cmd_q.npar <= ppres_q[2] ? 2'h3 : ppres_q[1] ? 2'h2 :
				ppres_q[0] ? 2'h1 : 2'h0;
			cmd_q.par_present <= ppres_q;
			cmd_q.par_is_float <= pflt_q;
			cmd_q.par0_int <= pint_q[0];
			cmd_q.par1_int <= pint_q[1];
			cmd_q.par2_int <= (pidx_q == 2'h2 && pneg_q) ? -pint_q[2] : pint_q[2];
		end
	end
	assign cmd_valid_out = state_q == ACP_ST_WAIT;
	assign cmd_out = cmd_q;

	always_ff @(posedge clk_in) begin
		if (srst_in)
			esr_q <= 8'h00;
		else begin
			// A failure in the cycle of a clear-status outlives the clear.
			if (do_cls)
				esr_q <= 8'h00;
			if (syntax_err)
				esr_q[acp_pkg::ESR_CMD_BIT] <= 1'b1;
			if (exec_fail_in)
				esr_q[acp_pkg::ESR_EXEC_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in)
			inst_stat_q <= 8'h00;
		else if (do_cls)
			inst_stat_q <= inst_stat_set_in ? inst_stat_bits_in :
				8'h00;
		else if (inst_stat_set_in)
			inst_stat_q <= inst_stat_q | inst_stat_bits_in;
	end

	// The queue drops the newest code when full, so the oldest cause stays.
	always_ff @(posedge clk_in) begin
		if (srst_in)
			errn_q <= 3'h0;
		else if (do_cls) begin
			// A cause reported with the clear stays as the only entry.
			errq_q[0] <= push_code;
			errn_q <= push_err ? 3'h1 : 3'h0;
		end else if (push_err && errn_q != 3'(acp_pkg::ERRQ_DEPTH)) begin
			errq_q[errn_q[1:0]] <= push_code;
			errn_q <= errn_q + 3'h1;
		end else if (err_pop_in && errn_q != 3'h0) begin
			for (int i = 0; i < acp_pkg::ERRQ_DEPTH - 1; i++)
				errq_q[i] <= errq_q[i+1];
			errn_q <= errn_q - 3'h1;
		end
	end

	assign esr_out = esr_q;
	assign inst_stat_out = inst_stat_q;
	assign err_empty_out = errn_q == 3'h0;
	assign err_code_out = errn_q == 3'h0 ? acp_pkg::ERR_NONE : errq_q[0];
	assign err_pop_in_unused_out = 1'b0;
	assign flush_out_out = flush_q;
endmodule // acp_parser
`default_nettype wire

// [acp_parser_props.sv]
// Concurrent checks on the command parser's top-level ports.
`timescale 1ns/100ps
`default_nettype none
module acp_parser_props (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic cmd_valid_out,
	input wire acp_pkg::acp_cmd_t cmd_out,
	input wire logic cmd_ready_in,
	input wire logic exec_fail_in,
	input wire logic [7:0] exec_code_in,
	input wire logic inst_stat_set_in,
	input wire logic [7:0] inst_stat_bits_in,
	input wire logic [7:0] inst_stat_out,
	input wire logic [7:0] esr_out,
	input wire logic err_pop_in,
	input wire logic [7:0] err_code_out,
	input wire logic err_empty_out,
	input wire logic flush_out_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	logic cls_w;
	assign cls_w = cmd_valid_out && cmd_ready_in && !cmd_out.query &&
		cmd_out.mnemonic == acp_pkg::MN_CLS;
	function automatic logic has_lower(logic [31:0] m);
		has_lower = 1'b0;
		for (int i = 0; i < 4; i++)
			if (m[8*i+:8] >= 8'h61 && m[8*i+:8] <= 8'h7A) has_lower = 1'b1;
	endfunction
	sequence exec_push;
		exec_fail_in && err_empty_out && !err_pop_in;
	endsequence
	sequence exec_seen;
		esr_out[4] && !err_empty_out && err_code_out == $past(exec_code_in);
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> // see RESET
		!cmd_valid_out && esr_out == 8'h00 && err_empty_out)
		else $error("outputs not quiet after reset");
	a_cmd_hold: assert property (cmd_valid_out && !cmd_ready_in |=>
		cmd_valid_out && $stable(cmd_out)) else $error("waiting command moved");
	a_cmd_drop: assert property (cmd_valid_out && cmd_ready_in |=>
		!cmd_valid_out) else $error("command not released");
	a_mnem_upper: assert property (cmd_valid_out |->
		!has_lower(cmd_out.mnemonic)) else $error("mnemonic not folded");
	a_cmd_err_sticky: assert property (esr_out[5] && !cls_w |=>
		esr_out[5]) else $error("command error flag lost");
	a_exec_err_hold: assert property (esr_out[4] && !cls_w |=>
		esr_out[4]) else $error("execution error flag lost");
	a_exec_queued: assert property (exec_push |=> exec_seen)
		else $error("execution failure not recorded");
	a_cls_clear: assert property (cls_w && !inst_stat_set_in &&
		!exec_fail_in |=> esr_out == 8'h00 && inst_stat_out == 8'h00 &&
		err_empty_out) else $error("clear status incomplete");
	a_inst_stat_set: assert property (inst_stat_set_in |=>
		(inst_stat_out & $past(inst_stat_bits_in)) ==
		$past(inst_stat_bits_in)) else $error("instrument status bits not set");
	a_empty_code: assert property (err_empty_out |->
		err_code_out == 8'h00) else $error("code shown on empty queue");
	a_flush_pulse: assert property (flush_out_out |=>
		!flush_out_out) else $error("flush longer than one cycle");
endmodule // acp_parser_props
`default_nettype wire

// [acp_pkg.sv]
// Package with constants and types for the ASCII command parser.
`default_nettype none
package acp_pkg;
	localparam int MNEM_LEN = 4;
	localparam int CMD_BUF_MAX = 255;
	localparam int PAR_BUF_MAX = 25;
	localparam int PAR_COUNT = 3;
	localparam int ESR_EXEC_BIT = 4;
	localparam int ESR_CMD_BIT = 5;
	localparam int FIFO_DEPTH = 16;
	localparam int ERRQ_DEPTH = 4;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_LOWER_BIT = 8'h20;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_PAR_OVF = 8'h6E;
	localparam logic [7:0] ERR_UNKNOWN = 8'h6F;
	localparam logic [7:0] ERR_SHORT = 8'h70;
	localparam logic [7:0] ERR_BAD_PAR = 8'h71;
	localparam logic [7:0] ERR_EXEC = 8'h72;
	localparam logic [31:0] MN_CLS = 32'h2A434C53;

	typedef enum logic [1:0] {
		ACP_PT_INT,
		ACP_PT_FREQ,
		ACP_PT_TIME,
		ACP_PT_VOLT
	} acp_ptype_t;

	typedef struct packed {
		logic [7:0] data;
		logic eoi;
	} acp_char_t;

	typedef struct packed {
		logic [31:0] mnemonic;
		logic query;
		logic [1:0] npar;
		logic [2:0] par_present;
		logic [2:0] par_is_float;
		logic [31:0] par0_int;
		logic [31:0] par1_int;
		logic [31:0] par2_int;
	} acp_cmd_t;
endpackage
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the ASCII command parser.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
	n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] rx_data_in, exec_code_in, inst_stat_bits_in, inst_stat_out;
	logic [7:0] esr_out, err_code_out;
	logic rx_eoi_in, rx_valid_in, rx_ready_out, cmd_valid_out, cmd_ready_in;
	logic exec_fail_in, inst_stat_set_in, err_pop_in, err_empty_out;
	logic flush_out_out;
	logic flush_seen = 1'b0;
	acp_pkg::acp_cmd_t cmd_out;
	int n_mismatch = 0;
	int check_count = 0;
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (flush_out_out === 1'b1) flush_seen <= 1'b1;
	// Short command buffer keeps the overflow run brief.
	acp_parser #(.CMD_MAX(40)) dut (.clk_in(clk_in), .srst_in(srst_in),
		.rx_data_in(rx_data_in), .rx_eoi_in(rx_eoi_in),
		.rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
		.cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
		.cmd_ready_in(cmd_ready_in), .exec_fail_in(exec_fail_in),
		.exec_code_in(exec_code_in), .inst_stat_set_in(inst_stat_set_in),
		.inst_stat_bits_in(inst_stat_bits_in),
		.inst_stat_out(inst_stat_out), .esr_out(esr_out),
		.err_pop_in_unused_out(), .err_pop_in(err_pop_in),
		.err_code_out(err_code_out), .err_empty_out(err_empty_out),
		.flush_out_out(flush_out_out));
	acp_host_model host (.clk_in(clk_in), .rx_ready_in(rx_ready_out),
		.rx_data_out(rx_data_in), .rx_eoi_out(rx_eoi_in),
		.rx_valid_out(rx_valid_in));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic expect_cmd(input logic [31:0] mn, input logic q,
		input logic [1:0] np, output acp_pkg::acp_cmd_t c);
		int n;
		n = 0;
		while (cmd_valid_out !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		`CHK(cmd_valid_out, 1'b1)
		c = cmd_out;
		cmd_ready_in = 1'b1;
		tick(1);
		cmd_ready_in = 1'b0;
		`CHK(c.mnemonic, mn)
		`CHK(c.query, q)
		`CHK(c.npar, np)
	endtask
	task automatic chk_err(input logic [7:0] code, input int b);
		int n;
		n = 0;
		while (err_empty_out !== 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		`CHK(err_code_out, code)
		`CHK(esr_out[b], 1'b1)
		`CHK(cmd_valid_out, 1'b0)
		err_pop_in = 1'b1;
		tick(1);
		err_pop_in = 1'b0;
		`CHK(err_empty_out, 1'b1)
	endtask
	task automatic t_set;
		acp_pkg::acp_cmd_t c;
		host.send("trat12", 1'b0);
		tick(20);
		`CHK(cmd_valid_out, 1'b0)
		host.send("\n", 1'b0);
		expect_cmd(32'h54524154, 1'b0, 2'h1, c);
		`CHK(c.par0_int, 32'h0000000C)
	endtask
	task automatic t_query;
		acp_pkg::acp_cmd_t c;
		string t[3] = '{";", "\r", "\n"};
		for (int i = 0; i < 3; i++) begin
			host.send({"*rst?", t[i]}, 1'b0);
			expect_cmd(32'h2A525354, 1'b1, 2'h0, c);
		end
	endtask
	task automatic t_params;
		acp_pkg::acp_cmd_t c;
		host.send("DLAY?7,8,-9\n", 1'b0);
		expect_cmd(32'h444C4159, 1'b1, 2'h3, c);
		`CHK(c.par_present, 3'h7)
		`CHK(c.par0_int, 32'h00000007)
		`CHK(c.par2_int, 32'hFFFFFFF7)
		host.send("TRAT1.5E3\n", 1'b0);
		expect_cmd(32'h54524154, 1'b0, 2'h1, c);
		`CHK(c.par_is_float, 3'h1)
	endtask
	task automatic t_eoi;
		acp_pkg::acp_cmd_t c;
		host.send("*OPC", 1'b1);
		expect_cmd(32'h2A4F5043, 1'b0, 2'h0, c);
	endtask
	task automatic t_errors;
		string s;
		host.send("ABCD\n", 1'b0);
		chk_err(8'h6F, 5);
		s = "TRAT";
		repeat (26) s = {s, "1"};
		host.send({s, "\n"}, 1'b0);
		chk_err(8'h6E, 5);
		host.send("*RS\n", 1'b0);
		chk_err(8'h70, 5);
		host.send("DLAY1,2,3,4\n", 1'b0);
		chk_err(8'h6E, 5);
		host.send("TRAT#\n", 1'b0);
		chk_err(8'h71, 5);
		exec_code_in = 8'h72;
		exec_fail_in = 1'b1;
		tick(1);
		exec_fail_in = 1'b0;
		chk_err(8'h72, 4);
	endtask
	task automatic t_ovf;
		acp_pkg::acp_cmd_t c;
		string s;
		s = "";
		repeat (41) s = {s, "A"};
		flush_seen = 1'b0;
		host.send(s, 1'b0);
		tick(10);
		`CHK(flush_seen, 1'b1)
		host.send("*OPC\n", 1'b0);
		expect_cmd(32'h2A4F5043, 1'b0, 2'h0, c);
	endtask
	task automatic t_cls;
		acp_pkg::acp_cmd_t c;
		inst_stat_bits_in = 8'hA5;
		inst_stat_set_in = 1'b1;
		tick(1);
		inst_stat_set_in = 1'b0;
		`CHK(inst_stat_out, 8'hA5)
		exec_fail_in = 1'b1;
		tick(1);
		exec_fail_in = 1'b0;
		`CHK(esr_out, 8'h30)
		host.send("*CLS\n", 1'b0);
		expect_cmd(acp_pkg::MN_CLS, 1'b0, 2'h0, c);
		`CHK(esr_out, 8'h00)
		`CHK(inst_stat_out, 8'h00)
		`CHK(err_empty_out, 1'b1)
	endtask
	task automatic results;
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cmd_ready_in = 1'b0;
		exec_fail_in = 1'b0;
		exec_code_in = 8'h00;
		inst_stat_set_in = 1'b0;
		inst_stat_bits_in = 8'h00;
		err_pop_in = 1'b0;
		tick(3);
		srst_in = 1'b0;
		t_set();
		t_query();
		t_params();
		t_eoi();
		t_errors();
		t_ovf();
		t_cls();
		results();
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		n_mismatch++;
		results();
	end
endmodule // tb_top
bind acp_parser acp_parser_props u_props (.clk_in(clk_in), .srst_in(srst_in),
	.cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
	.cmd_ready_in(cmd_ready_in), .exec_fail_in(exec_fail_in),
	.exec_code_in(exec_code_in), .inst_stat_set_in(inst_stat_set_in),
	.inst_stat_bits_in(inst_stat_bits_in),
	.inst_stat_out(inst_stat_out), .esr_out(esr_out),
	.err_pop_in(err_pop_in), .err_code_out(err_code_out),
	.err_empty_out(err_empty_out), .flush_out_out(flush_out_out));
`default_nettype wire
